// ---- pel_xform_pkg.sv ----
// shared constants, register map and carrier types for the pel transform unit
// What this block does
// - trapezium extra x from source x register
// - arc radius and stop from dedicated registers
// - short increment flag selects packed short dimensions, except for access commands
// - access commands address viewport via source pointer
// - dimensions coded sign plus 11-bit magnitude; short ones 7-bit, cell width unsigned
// - destination mask enable protects clear-mask pels
// - source mask enable makes clear-mask pels transparent in polychrome
// - source mask disabled maps colour regardless
// - two 8-bit colours in own registers
// - bank parity picks colour nibble
// - colour code: first, second, keep, complement
// - mask code: clear, set, keep, complement
// - colour then mask, independently per pel
// - bichrome: separate foreground and background transforms
// - polychrome activity, window clip, destination mask
// - dot pen monochrome, cell pen bi/polychrome
// - object pen forces source mask, texture gate
// - scale 1..16 only for print and cell pen
// - scale before mapping, direction from height signs
// - negative cell height mirrors vertically
package pel_xform_pkg;
	localparam int REG_W = 16;
	localparam int NUM_REGS = 26;
	localparam int IDX_W = 5;
	// register indices; byte address is four times the index
	localparam logic [4:0] IDX_DRAWING_MODE = 5'h00;
	localparam logic [4:0] IDX_FIRST_COLOR = 5'h01;
	localparam logic [4:0] IDX_SECOND_COLOR = 5'h02;
	localparam logic [4:0] IDX_LINE_TEXTURE = 5'h03;
	localparam logic [4:0] IDX_COMMAND_CTRL = 5'h0b;
	localparam logic [4:0] IDX_SHORT_DIMS = 5'h0d;
	localparam logic [4:0] IDX_DEST_X = 5'h0e;
	localparam logic [4:0] IDX_DEST_Y = 5'h0f;
	localparam logic [4:0] IDX_DEST_WIDTH = 5'h10;
	localparam logic [4:0] IDX_DEST_HEIGHT = 5'h11;
	localparam logic [4:0] IDX_ARC_RADIUS = 5'h12;
	localparam logic [4:0] IDX_ARC_STOP = 5'h13;
	localparam logic [4:0] IDX_SOURCE_Y = 5'h14;
	localparam logic [4:0] IDX_SOURCE_X = 5'h15;
	localparam logic [4:0] IDX_CELL_HEIGHT = 5'h16;
	localparam logic [4:0] IDX_CELL_WIDTH = 5'h17;
	localparam logic [4:0] IDX_SCALE = 5'h18;
	localparam logic [4:0] IDX_STATUS = 5'h19;
	localparam logic [15:0] RESET_VALUE = 16'h0000;
	localparam logic [15:0] SCALE_RESET = 16'h0000;
	// drawing mode field positions
	localparam int FG_COLOR_LSB = 0;
	localparam int FG_MASK_LSB = 2;
	localparam int BG_COLOR_LSB = 4;
	localparam int BG_MASK_LSB = 6;
	localparam int MODE_LSB = 8;
	localparam int DME_BIT = 10;
	localparam int SME_BIT = 11;
	localparam int SHORT_BIT = 12;
	// command control field positions
	localparam int CLASS_LSB = 0;
	localparam int PEN_LSB = 2;
	localparam int TRAP_BIT = 4;
	localparam int SIGN_BIT = 11;
	localparam int MAG_W = 11;
	localparam int SHORT_MAG_W = 7;
	localparam int WORD_PELS = 8;
	localparam int ADDR_W = 24;
	typedef enum logic [1:0] {CC_FIRST = 2'b00, CC_SECOND = 2'b01, CC_KEEP = 2'b10,
		CC_INVERT = 2'b11} color_code_type;
	typedef enum logic [1:0] {MC_CLEAR = 2'b00, MC_SET = 2'b01, MC_KEEP = 2'b10,
		MC_INVERT = 2'b11} mask_code_type;
	typedef enum logic [1:0] {DM_MONO = 2'b00, DM_BICHROME = 2'b01, DM_POLY = 2'b10,
		DM_RSVD = 2'b11} draw_mode_type;
	typedef enum logic [1:0] {CL_LINEAR = 2'b00, CL_AREA = 2'b01, CL_PRINT = 2'b10,
		CL_ACCESS = 2'b11} cmd_class_type;
	typedef enum logic [1:0] {PEN_DOT = 2'b00, PEN_CHAR = 2'b01, PEN_OBJECT = 2'b10,
		PEN_RSVD = 2'b11} pen_type;
	typedef struct packed {
		logic neg;
		logic [10:0] mag;
	} smag_type;
	// one pel from the geometry generators
	typedef struct packed {
		logic [23:0] word_addr;
		logic [2:0] lane;
		logic [1:0] bank;
		logic in_window;
		logic foreground;
		logic [3:0] src_color;
		logic src_mask;
		logic new_coord;
	} pel_req_type;
	// display memory word: eight short pels plus their mask bits
	typedef struct packed {
		logic [7:0][3:0] color;
		logic [7:0] mask;
	} mem_word_type;
	// arguments handed to the geometry generators
	typedef struct packed {
		smag_type width;
		smag_type height;
		smag_type cell_h;
		logic [10:0] cell_w;
		logic [15:0] extra_x;
		logic [15:0] radius;
		logic [15:0] stop;
		logic [15:0] view_x;
		logic [15:0] view_y;
		logic [4:0] scale_x;
		logic [4:0] scale_y;
		logic mirror_v;
		logic flip_dest;
	} geom_type;
endpackage

// ---- pel_raster_transform_unit.sv ----
// pel transform unit: apb registers, argument routing and per-pel read-modify-write
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module pel_raster_transform_unit (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_pel_valid,
	input wire pel_xform_pkg::pel_req_type i_pel,
	output logic o_pel_ready,
	output logic o_mem_rd,
	output logic [23:0] o_mem_addr,
	input wire logic i_mem_rd_valid,
	input wire pel_xform_pkg::mem_word_type i_mem_rdata,
	output logic o_mem_wr,
	output pel_xform_pkg::mem_word_type o_mem_wdata,
	input wire logic i_mem_wr_ready,
	output pel_xform_pkg::geom_type o_geom
);
	import pel_xform_pkg::*;

	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_FETCH = 2'b01, ST_STORE = 2'b10,
		ST_SPARE = 2'b11} rmw_state_type;

	logic [15:0] regs_ff [NUM_REGS];
	rmw_state_type state_ff, nxt_state;
	pel_req_type pel_ff;
	mem_word_type word_ff, nxt_word;
	logic [23:0] addr_ff;
	logic [15:0] writes_ff;
	logic tex_bit_ff;

	// apb decode; index taken from the word address
	wire logic [4:0] reg_idx = i_paddr[6:2];
	wire logic mapped = (i_paddr[7] == 1'b0) && (reg_idx < 5'(NUM_REGS));
	wire logic acc_phase = i_psel && i_penable;
	wire logic reg_wr = acc_phase && i_pwrite && mapped && (reg_idx != IDX_STATUS);
	wire logic pel_take = i_pel_valid && o_pel_ready;

	// decoded control fields
	wire logic [15:0] mode_reg = regs_ff[IDX_DRAWING_MODE];
	wire logic [15:0] ctrl_reg = regs_ff[IDX_COMMAND_CTRL];
	wire logic [15:0] texture = regs_ff[IDX_LINE_TEXTURE];
	wire draw_mode_type mode = draw_mode_type'(mode_reg[MODE_LSB +: 2]);
	wire cmd_class_type cls = cmd_class_type'(ctrl_reg[CLASS_LSB +: 2]);
	wire pen_type pen = pen_type'(ctrl_reg[PEN_LSB +: 2]);
	wire logic dest_mask_enable = mode_reg[DME_BIT];
	wire logic linear_cmd = (cls == CL_LINEAR);
	wire logic object_pen = linear_cmd && (pen == PEN_OBJECT);
	wire logic cell_pen = linear_cmd && (pen != PEN_DOT);
	// an object pen always runs with the source mask honoured
	wire logic src_mask_enable = mode_reg[SME_BIT] || object_pen;

	// effective drawing mode: a dot pen is forced monochrome, a cell pen follows its cell
	wire draw_mode_type eff_mode = !linear_cmd ? mode :
		(pen == PEN_DOT) ? DM_MONO :
		(pen == PEN_CHAR) ? DM_BICHROME : DM_POLY;

	// apb: zero wait states; unmapped addresses answer an error and read zero
	assign o_pready = 1'b1;
	assign o_pslverr = acc_phase && !mapped;
	assign o_prdata = mapped ? {16'h0000, regs_ff[reg_idx]} : 32'h0000_0000;

	// register file; status is hardware-owned, texture rotates per coordinate
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			for (int i = 0; i < NUM_REGS; i++) regs_ff[i] <= RESET_VALUE;
		end else begin
			for (int i = 0; i < NUM_REGS; i++) begin
				if (reg_wr && (reg_idx == 5'(i))) regs_ff[i] <= i_pwdata[15:0];
			end
			// hardware rotation wins a collision with a software write
			if (pel_take && i_pel.new_coord && linear_cmd)
				regs_ff[IDX_LINE_TEXTURE] <= {texture[0], texture[15:1]};
			regs_ff[IDX_STATUS] <= {writes_ff[13:0], (state_ff != ST_IDLE), o_pel_ready};
		end
	end

	// sign-magnitude decode of the standard and short dimensions
	wire smag_type std_w = smag_type'(regs_ff[IDX_DEST_WIDTH][SIGN_BIT:0]);
	wire smag_type std_h = smag_type'(regs_ff[IDX_DEST_HEIGHT][SIGN_BIT:0]);
	wire logic [15:0] short_r = regs_ff[IDX_SHORT_DIMS];
	wire smag_type short_w = '{neg: short_r[7], mag: 11'(short_r[SHORT_MAG_W-1:0])};
	wire smag_type short_h = '{neg: short_r[15], mag: 11'(short_r[14:8])};
	wire logic use_short = mode_reg[SHORT_BIT] && (cls != CL_ACCESS);

	// scale factors stored as value minus one; unscaled commands see one
	wire logic scaled = (cls == CL_PRINT) || cell_pen;
	wire logic [4:0] sx_raw = 5'(regs_ff[IDX_SCALE][3:0]) + 5'h01;
	wire logic [4:0] sy_raw = 5'(regs_ff[IDX_SCALE][7:4]) + 5'h01;

	// arguments routed to the geometry generators
	assign o_geom.width = use_short ? short_w : std_w;
	assign o_geom.height = use_short ? short_h : std_h;
	assign o_geom.cell_h = smag_type'(regs_ff[IDX_CELL_HEIGHT][SIGN_BIT:0]);
	// cell width carries no sign bit at all
	assign o_geom.cell_w = regs_ff[IDX_CELL_WIDTH][MAG_W-1:0];
	assign o_geom.extra_x = ctrl_reg[TRAP_BIT] ? regs_ff[IDX_SOURCE_X] : 16'h0000;
	assign o_geom.radius = regs_ff[IDX_ARC_RADIUS];
	assign o_geom.stop = regs_ff[IDX_ARC_STOP];
	// access viewport comes from the source pointer, never the data buffer regs
	assign o_geom.view_x = (cls == CL_ACCESS) ? regs_ff[IDX_SOURCE_X] : regs_ff[IDX_DEST_X];
	assign o_geom.view_y = (cls == CL_ACCESS) ? regs_ff[IDX_SOURCE_Y] : regs_ff[IDX_DEST_Y];
	assign o_geom.scale_x = scaled ? sx_raw : 5'h01;
	assign o_geom.scale_y = scaled ? sy_raw : 5'h01;
	// a negative cell height flips the cell rows; a cell pen ignores the line signs
	assign o_geom.mirror_v = o_geom.cell_h.neg;
	assign o_geom.flip_dest = !cell_pen && o_geom.height.neg;

	// per-pel activity, computed on the fetched word
	wire logic [2:0] lane = pel_ff.lane;
	wire logic old_mask = i_mem_rdata.mask[lane];
	wire logic [3:0] old_color = i_mem_rdata.color[lane];
	wire logic dmask_ok = !dest_mask_enable || old_mask;
	wire logic smask_ok = !src_mask_enable || pel_ff.src_mask;
	// the gate is the bit rotated out at the coordinate, not the new low bit
	wire logic tex_ok = !linear_cmd || tex_bit_ff;
	wire logic poly = (eff_mode == DM_POLY);
	wire logic active = pel_ff.in_window && dmask_ok && tex_ok && (!poly || smask_ok);

	// bichrome picks foreground or background codes; mono/poly use the foreground pair
	wire logic use_bg = (eff_mode == DM_BICHROME) && !pel_ff.foreground;
	wire color_code_type ccode = color_code_type'(use_bg ? mode_reg[BG_COLOR_LSB +: 2] :
		mode_reg[FG_COLOR_LSB +: 2]);
	wire mask_code_type mcode = mask_code_type'(use_bg ? mode_reg[BG_MASK_LSB +: 2] :
		mode_reg[FG_MASK_LSB +: 2]);

	// bank parity selects the colour nibble
	wire logic [7:0] c_first = regs_ff[IDX_FIRST_COLOR][7:0];
	wire logic [7:0] c_second = regs_ff[IDX_SECOND_COLOR][7:0];
	wire logic [3:0] nib_first = pel_ff.bank[0] ? c_first[7:4] : c_first[3:0];
	wire logic [3:0] nib_second = pel_ff.bank[0] ? c_second[7:4] : c_second[3:0];

	// colour transform first; the mask transform never looks at the new colour
	logic [3:0] new_color;
	logic new_mask;
	always_comb begin
		if (poly) begin
			new_color = pel_ff.src_color;
		end else begin
			case (ccode)
				CC_FIRST: new_color = nib_first;
				CC_SECOND: new_color = nib_second;
				CC_KEEP: new_color = old_color;
				CC_INVERT: new_color = ~old_color;
				default: new_color = old_color;
			endcase
		end
		case (mcode)
			MC_CLEAR: new_mask = 1'b0;
			MC_SET: new_mask = 1'b1;
			MC_KEEP: new_mask = old_mask;
			MC_INVERT: new_mask = ~old_mask;
			default: new_mask = old_mask;
		endcase
	end

	// merge into the fetched word so neighbouring pels keep their values
	always_comb begin
		nxt_word = i_mem_rdata;
		nxt_word.color[lane] = new_color;
		nxt_word.mask[lane] = new_mask;
	end

	// rmw sequencer; an inactive pel skips the write to save a memory cycle
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (pel_take) nxt_state = ST_FETCH;
			end
			ST_FETCH: begin
				if (i_mem_rd_valid) nxt_state = active ? ST_STORE : ST_IDLE;
			end
			ST_STORE: begin
				if (i_mem_wr_ready) nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) state_ff <= ST_IDLE;
		else state_ff <= nxt_state;
	end

	// request capture and merged word
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			pel_ff <= '0;
			addr_ff <= '0;
			word_ff <= '0;
			tex_bit_ff <= 1'b0;
		end else begin
			if (pel_take) pel_ff <= i_pel;
			// held for every pel of one coordinate so a cell pen is gated as a whole
			if (pel_take && i_pel.new_coord) tex_bit_ff <= texture[0];
			if (pel_take) addr_ff <= i_pel.word_addr;
			if ((state_ff == ST_FETCH) && i_mem_rd_valid) word_ff <= nxt_word;
		end
	end

	// count of completed writes, shown in status
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) writes_ff <= '0;
		else if ((state_ff == ST_STORE) && i_mem_wr_ready) writes_ff <= writes_ff + 16'h0001;
	end

	// handshakes are combinational from state; data from flops
	assign o_pel_ready = (state_ff == ST_IDLE);
	assign o_mem_rd = (state_ff == ST_FETCH);
	assign o_mem_wr = (state_ff == ST_STORE);
	assign o_mem_addr = addr_ff;
	assign o_mem_wdata = word_ff;

	// checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	AST_DEST_MASK_BLOCKS: assert property (
		(state_ff == ST_FETCH) && i_mem_rd_valid && dest_mask_enable && !old_mask
		|=> state_ff == ST_IDLE)
		else $error("masked destination pel was written");
	AST_TRANSPARENT_SRC: assert property (
		(state_ff == ST_FETCH) && i_mem_rd_valid && poly && src_mask_enable
		&& !pel_ff.src_mask |=> !o_mem_wr)
		else $error("transparent source pel was written");
	AST_SRC_MASK_OFF: assert property (
		(state_ff == ST_FETCH) && i_mem_rd_valid && poly && !src_mask_enable
		&& pel_ff.in_window && dmask_ok && tex_ok
		|=> o_mem_wr && o_mem_wdata.color[lane] == pel_ff.src_color)
		else $error("source colour not mapped with source mask off");
	AST_COLOR_FIRST: assert property (
		(state_ff == ST_FETCH) && i_mem_rd_valid && active && !poly && ccode == CC_FIRST
		|=> o_mem_wdata.color[lane] == nib_first)
		else $error("first colour not written");
	AST_COLOR_INVERT: assert property (
		(state_ff == ST_FETCH) && i_mem_rd_valid && active && !poly && ccode == CC_INVERT
		|=> o_mem_wdata.color[lane] == ~$past(old_color))
		else $error("colour not complemented");
	AST_MASK_INVERT: assert property (
		(state_ff == ST_FETCH) && i_mem_rd_valid && active && mcode == MC_INVERT
		|=> o_mem_wdata.mask[lane] == ~$past(old_mask))
		else $error("mask bit not complemented");
	AST_NEIGHBOURS_KEPT: assert property (
		(state_ff == ST_FETCH) && i_mem_rd_valid && active
		|=> o_mem_wdata.mask[lane + 3'h1] == $past(i_mem_rdata.mask[lane + 3'h1]))
		else $error("neighbour pel disturbed");
	AST_NIBBLE_PARITY: assert property (
		(state_ff == ST_FETCH) && i_mem_rd_valid && active && !poly && ccode == CC_SECOND
		&& pel_ff.bank[0] |=> o_mem_wdata.color[lane] == regs_ff[IDX_SECOND_COLOR][7:4])
		else $error("odd bank must use high nibble");
	AST_SHORT_DIMS: assert property (
		use_short |-> o_geom.width.mag == 11'(short_r[6:0]) && o_geom.width.neg == short_r[7])
		else $error("short dimensions not selected");
	AST_SCALE_UNIT: assert property (
		(cls == CL_AREA || cls == CL_ACCESS) |-> o_geom.scale_x == 5'h01
		&& o_geom.scale_y == 5'h01)
		else $error("unscaled command got a scale factor");
	AST_TEXTURE_ROTATE: assert property (
		pel_take && i_pel.new_coord && linear_cmd |=> texture == {$past(texture[0]),
		$past(texture[15:1])})
		else $error("texture did not rotate");
	AST_RMW_ORDER: assert property (
		pel_take |=> o_mem_rd ##0 (!o_mem_wr throughout (o_mem_rd [*1])))
		else $error("write issued before read");

	COV_WRITE_PEL: cover property (o_mem_wr && i_mem_wr_ready);
	COV_BICHROME_BG: cover property (state_ff == ST_FETCH && i_mem_rd_valid && use_bg && active);
	COV_MASK_SKIP: cover property (state_ff == ST_FETCH && i_mem_rd_valid && !dmask_ok);
	COV_POLY_TRANSP: cover property (state_ff == ST_FETCH && i_mem_rd_valid && poly && !smask_ok);
endmodule // pel_raster_transform_unit

// ---- display_mem_model.sv ----
// display memory partner model: a small word store behind read and write handshakes
`timescale 1ns/1ps
module display_mem_model (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_slow,
	input wire logic i_mem_rd,
	input wire logic [23:0] i_mem_addr,
	input wire logic i_mem_wr,
	input wire pel_xform_pkg::mem_word_type i_mem_wdata,
	output logic o_mem_rd_valid,
	output pel_xform_pkg::mem_word_type o_mem_rdata,
	output logic o_mem_wr_ready
);
	import pel_xform_pkg::*;
	mem_word_type words [16];
	logic [2:0] wait_ff;
	// outside an answer the data lines show the inverse, so a stale sample is caught
	assign o_mem_rdata = o_mem_rd_valid ? words[i_mem_addr[3:0]] : ~words[i_mem_addr[3:0]];
	// answers after one or four cycles; the slow case stretches how long requests must hold
	always @(posedge i_mclk) begin
		o_mem_rd_valid <= 1'b0;
		o_mem_wr_ready <= 1'b0;
		if (o_mem_wr_ready) begin
			words[i_mem_addr[3:0]] <= i_mem_wdata;
		end
		if (!i_reset_n) begin
			wait_ff <= 3'h0;
		end else if ((i_mem_rd || i_mem_wr) && !o_mem_rd_valid && !o_mem_wr_ready) begin
			if (wait_ff >= (i_slow ? 3'h3 : 3'h0)) begin
				wait_ff <= 3'h0;
				o_mem_rd_valid <= i_mem_rd;
				o_mem_wr_ready <= i_mem_wr;
			end else begin
				wait_ff <= wait_ff + 3'h1;
			end
		end
	end
endmodule // display_mem_model

// ---- test_pel_raster_transform_unit.sv ----
// self-checking testbench for the pel transform unit with a display memory model
`timescale 1ns/1ps
module test_pel_raster_transform_unit;
	import pel_xform_pkg::*;
	localparam mem_word_type BASE = {32'h8421_96a5, 8'h5a};
	logic i_mclk = 1'b0;
	logic i_reset_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pel_valid = 1'b0, slow = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, pel_ready, mem_rd, mem_wr, rd_valid, wr_ready;
	pel_req_type pel = '0;
	logic [23:0] mem_addr;
	mem_word_type rdata, wdata;
	geom_type geom;
	int failures = 0;
	int samples_checked = 0;
	// free-running clock, 4 ns period
	always #2 i_mclk = ~i_mclk;
	pel_raster_transform_unit pel_raster_transform_unit_i (.i_mclk(i_mclk),
		.i_reset_n(i_reset_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_pel_valid(pel_valid), .i_pel(pel), .o_pel_ready(pel_ready),
		.o_mem_rd(mem_rd), .o_mem_addr(mem_addr), .i_mem_rd_valid(rd_valid),
		.i_mem_rdata(rdata), .o_mem_wr(mem_wr), .o_mem_wdata(wdata),
		.i_mem_wr_ready(wr_ready), .o_geom(geom));
	display_mem_model display_mem_model_i (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.i_slow(slow), .i_mem_rd(mem_rd), .i_mem_addr(mem_addr), .i_mem_wr(mem_wr),
		.i_mem_wdata(wdata), .o_mem_rd_valid(rd_valid), .o_mem_rdata(rdata),
		.o_mem_wr_ready(wr_ready));
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic timed_out;
		failures++;
		$display("wait limit reached at %0t", $time);
		final_report();
	endtask
	task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_word(input mem_word_type got, input mem_word_type exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [4:0] idx, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge i_mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {1'b0, idx, 2'b00};
		pwdata <= d;
		@(posedge i_mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) timed_out();
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] idx, input logic [15:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, idx, {16'h0, d}, q, e);
	endtask
	function automatic logic [15:0] dm(input logic [1:0] fc, fm, bc, bm, md,
		input logic dme, sme);
		dm = {4'h0, sme, dme, md, bm, bc, fm, fc};
	endfunction
	function automatic pel_req_type mk(input logic [1:0] b, input logic [2:0] l,
		input logic fg, input logic [3:0] sc, input logic sm);
		mk = {24'h000005, l, b, 1'b1, fg, sc, sm, 1'b1};
	endfunction
	function automatic mem_word_type put(input mem_word_type w, input logic [2:0] l,
		input logic [3:0] c, input logic m);
		put = w;
		put.color[l] = c;
		put.mask[l] = m;
	endfunction
	// presets the word, hands one pel over, waits for idle and judges the stored word
	task automatic pel_case(input pel_req_type p, input mem_word_type exp);
		int n;
		display_mem_model_i.words[p.word_addr[3:0]] = BASE;
		@(posedge i_mclk);
		pel_valid <= 1'b1;
		pel <= p;
		n = 0;
		do begin
			@(posedge i_mclk);
			n++;
		end while (pel_ready !== 1'b1 && n < 40);
		if (n >= 40) timed_out();
		pel_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge i_mclk);
			n++;
		end while (pel_ready !== 1'b1 && n < 40);
		if (n >= 40) timed_out();
		check_word(display_mem_model_i.words[p.word_addr[3:0]], exp);
	endtask
	task automatic test_regs;
		logic [31:0] q;
		logic e;
		apb(1'b0, IDX_FIRST_COLOR, 32'h0, q, e);
		check_reg(q, 32'h0);
		wr(IDX_FIRST_COLOR, 16'h003c);
		wr(IDX_SECOND_COLOR, 16'h009e);
		apb(1'b0, IDX_FIRST_COLOR, 32'h0, q, e);
		check_reg(q, 32'h3c);
		apb(1'b0, IDX_SECOND_COLOR, 32'h0, q, e);
		check_reg(q, 32'h9e);
		apb(1'b1, 5'h1f, 32'h1234, q, e);
		check_reg({31'h0, e}, 32'h1);
		$display("test_regs done");
	endtask
	task automatic test_geom;
		wr(IDX_COMMAND_CTRL, 16'h0012);
		wr(IDX_SOURCE_X, 16'h0abc);
		wr(IDX_ARC_RADIUS, 16'h0123);
		wr(IDX_ARC_STOP, 16'h0456);
		wr(IDX_DEST_WIDTH, 16'h0005);
		wr(IDX_DEST_HEIGHT, 16'h0807);
		wr(IDX_CELL_HEIGHT, 16'h0803);
		wr(IDX_SCALE, 16'h00f0);
		@(posedge i_mclk);
		check_reg({16'h0, geom.extra_x}, 32'h0abc);
		check_reg({geom.radius, geom.stop}, 32'h0123_0456);
		check_reg({8'h0, geom.width, geom.height}, 32'h0000_5807);
		check_reg({30'h0, geom.flip_dest, geom.mirror_v}, 32'h3);
		check_reg({22'h0, geom.scale_y, geom.scale_x}, {22'h0, 5'h10, 5'h01});
		wr(IDX_DRAWING_MODE, 16'h1000);
		wr(IDX_SHORT_DIMS, 16'h0285);
		@(posedge i_mclk);
		check_reg({8'h0, geom.width, geom.height}, 32'h0080_5002);
		wr(IDX_COMMAND_CTRL, 16'h0003);
		@(posedge i_mclk);
		check_reg({geom.extra_x, geom.view_x}, 32'h0000_0abc);
		$display("test_geom done");
	endtask
	task automatic test_color;
		logic [3:0] ev [4] = '{4'hc, 4'he, 4'h6, 4'h9};
		logic [3:0] od [4] = '{4'h3, 4'h9, 4'h6, 4'h9};
		wr(IDX_COMMAND_CTRL, 16'h0001);
		for (int c = 0; c < 4; c++) begin
			wr(IDX_DRAWING_MODE, dm(c[1:0], 2'b10, 2'b10, 2'b10, 2'b00, 1'b0, 1'b0));
			pel_case(mk(2'h0, 3'h2, 1'b1, 4'h0, 1'b0), put(BASE, 3'h2, ev[c], 1'b0));
			pel_case(mk(2'h1, 3'h2, 1'b1, 4'h0, 1'b0), put(BASE, 3'h2, od[c], 1'b0));
		end
		$display("test_color done");
	endtask
	task automatic test_mask;
		logic [3:0] em2 = 4'b1010;
		logic [3:0] em1 = 4'b0110;
		for (int m = 0; m < 4; m++) begin
			wr(IDX_DRAWING_MODE, dm(2'b11, m[1:0], 2'b10, 2'b10, 2'b00, 1'b0, 1'b0));
			pel_case(mk(2'h0, 3'h2, 1'b1, 4'h0, 1'b0), put(BASE, 3'h2, 4'h9, em2[m]));
			pel_case(mk(2'h0, 3'h1, 1'b1, 4'h0, 1'b0), put(BASE, 3'h1, 4'h5, em1[m]));
		end
		$display("test_mask done");
	endtask
	task automatic test_dmask;
		wr(IDX_DRAWING_MODE, dm(2'b00, 2'b10, 2'b10, 2'b10, 2'b00, 1'b1, 1'b0));
		pel_case(mk(2'h0, 3'h2, 1'b1, 4'h0, 1'b0), BASE);
		pel_case(mk(2'h0, 3'h1, 1'b1, 4'h0, 1'b0), put(BASE, 3'h1, 4'hc, 1'b1));
		$display("test_dmask done");
	endtask
	task automatic test_poly;
		pel_req_type p = mk(2'h0, 3'h2, 1'b1, 4'h7, 1'b1);
		wr(IDX_COMMAND_CTRL, 16'h0002);
		wr(IDX_DRAWING_MODE, dm(2'b00, 2'b10, 2'b00, 2'b10, 2'b10, 1'b0, 1'b1));
		pel_case(mk(2'h0, 3'h2, 1'b1, 4'h7, 1'b0), BASE);
		pel_case(p, put(BASE, 3'h2, 4'h7, 1'b0));
		p.in_window = 1'b0;
		pel_case(p, BASE);
		wr(IDX_DRAWING_MODE, dm(2'b00, 2'b10, 2'b00, 2'b10, 2'b10, 1'b0, 1'b0));
		pel_case(mk(2'h0, 3'h2, 1'b1, 4'h7, 1'b0), put(BASE, 3'h2, 4'h7, 1'b0));
		$display("test_poly done");
	endtask
	task automatic test_bichrome;
		wr(IDX_DRAWING_MODE, dm(2'b00, 2'b01, 2'b01, 2'b00, 2'b01, 1'b0, 1'b0));
		pel_case(mk(2'h0, 3'h2, 1'b1, 4'h0, 1'b0), put(BASE, 3'h2, 4'hc, 1'b1));
		pel_case(mk(2'h1, 3'h1, 1'b0, 4'h0, 1'b0), put(BASE, 3'h1, 4'h9, 1'b0));
		$display("test_bichrome done");
	endtask
	task automatic test_texture;
		wr(IDX_COMMAND_CTRL, 16'h0008);
		wr(IDX_DRAWING_MODE, dm(2'b00, 2'b10, 2'b00, 2'b10, 2'b00, 1'b0, 1'b0));
		wr(IDX_LINE_TEXTURE, 16'h0001);
		wr(IDX_SCALE, 16'h0000);
		@(posedge i_mclk);
		check_reg({21'h0, geom.flip_dest, geom.scale_y, geom.scale_x}, 32'h21);
		pel_case(mk(2'h0, 3'h2, 1'b1, 4'h7, 1'b1), put(BASE, 3'h2, 4'h7, 1'b0));
		pel_case(mk(2'h0, 3'h2, 1'b1, 4'h7, 1'b1), BASE);
		wr(IDX_LINE_TEXTURE, 16'hffff);
		pel_case(mk(2'h0, 3'h2, 1'b1, 4'h7, 1'b0), BASE);
		$display("test_texture done");
	endtask
	// reset for ten cycles, then every scenario in turn
	initial begin
		repeat (10) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		test_regs();
		test_geom();
		test_color();
		test_mask();
		test_dmask();
		test_poly();
		slow <= 1'b1;
		test_bichrome();
		test_texture();
		final_report();
	end
endmodule // test_pel_raster_transform_unit
